/* design/ssac_eeprom_ctrl.v */
// serial eeprom access control: ahb-lite register slave, clock divider,
// autoload result flags, interrupt logic and the cycle engine instance
// assumes one 25 MHz clock; autoload sequencing lives outside this block
//
// Behaviour
// - writing one to start bit begins one eeprom read or write cycle
// - command bit picks direction: zero reads, one writes; resets to zero
// - error flag sets when eeprom gives no acknowledge during a cycle
// - success bit reads one only after a successful autoload
// - reading the success bit clears it until a new autoload succeeds
// - autoload status bit shows success after fundamental reset; resets zero
// - autoload disable bit reads one when disabled; resets to one
// - clock rate field sets eeprom clock; 01 is core/1024, 11 test
// - control register sits at offset bc of the upstream port
// - data field supplies write word and holds the word read back
// - seven-bit address field selects eeprom word; resets to zero
//
// The implementer's own choice: the AHB-Lite register port.
`include "ssac_eeprom_regs.vh"

module ssac_eeprom_ctrl #(
   parameter DEV_ADDR = 7'h50
)(
   input wire clk_sys_i,
   input wire nrst_i,
   input wire hsel_i,
   input wire [7:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire [31:0] hwdata_i,
   output reg [31:0] hrdata_o,
   output reg hreadyout_o,
   output reg hresp_o,
   input wire autoload_en_i,
   input wire autoload_done_i,
   input wire autoload_ok_i,
   input wire sda_i,
   output wire scl_o,
   output wire sda_oe_o,
   output reg sda_o,
   output reg irq_o
);

   // quarter count rounded up: the divided eeprom clock may run slow, never fast
   localparam integer QTR_I = `SSAC_QTR_CYC - 1;
   localparam [5:0] QTR_LAST = QTR_I[5:0];

   ////////////////////////////////////////////////////////////////
   // register state
   reg start_ff;
   reg cmd_ff;
   reg err_ff;
   reg al_succ_ff;
   reg al_stat_ff;
   reg al_dis_ff;
   reg strap_taken_ff;
   reg [1:0] rate_ff;
   reg [6:0] addr_ff;
   reg [15:0] data_ff;
   reg [`SSAC_IRQ_W-1:0] irq_sts_ff;
   reg [`SSAC_IRQ_W-1:0] irq_msk_ff;
   reg go_ff;
   reg [5:0] div_ff;
   reg tick_ff;

   // bus pipeline
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [7:0] addr_q_ff;

   wire eng_busy;
   wire eng_done;
   wire eng_nack;
   wire [15:0] eng_rdata;
   wire addr_phase;
   wire wr_ctrl;
   wire rd_ctrl;
   wire al_good;
   wire [`SSAC_IRQ_W-1:0] irq_set;
   wire [`SSAC_IRQ_W-1:0] irq_clr;
   wire [`SSAC_IRQ_W-1:0] nxt_irq_sts;
   reg [31:0] nxt_rdata;

   function [31:0] ctrl_word;
      input s;
      input c;
      input e;
      input sc;
      input st;
      input ds;
      input [1:0] r;
      input [6:0] a;
      input [15:0] d;
      begin
         ctrl_word = 32'h00000000;
         ctrl_word[`SSAC_B_START] = s;
         ctrl_word[`SSAC_B_CMD] = c;
         ctrl_word[`SSAC_B_ERR] = e;
         ctrl_word[`SSAC_B_AL_SUCC] = sc;
         ctrl_word[`SSAC_B_AL_STAT] = st;
         ctrl_word[`SSAC_B_AL_DIS] = ds;
         ctrl_word[`SSAC_F_RATE_HI:`SSAC_F_RATE_LO] = r;
         ctrl_word[`SSAC_F_ADDR_HI:`SSAC_F_ADDR_LO] = a;
         ctrl_word[`SSAC_F_DATA_HI:`SSAC_F_DATA_LO] = d;
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // ahb-lite decode
   assign addr_phase = hsel_i && hready_i && htrans_i[1];
   assign wr_ctrl = wr_pend_ff && (addr_q_ff == `SSAC_OFF_CTRL);
   assign rd_ctrl = rd_pend_ff && !hreadyout_o && (addr_q_ff == `SSAC_OFF_CTRL);

   // reads take one wait state so a write just before is already visible
   // writes need none: the data phase edge updates the register directly
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_q_ff <= 8'h00;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         hrdata_o <= 32'h00000000;
      end
      else
      begin
         wr_pend_ff <= 1'b0;
         if (rd_pend_ff)
         begin
            rd_pend_ff <= 1'b0;
            hreadyout_o <= 1'b1;
            hrdata_o <= nxt_rdata;
         end
         else if (addr_phase)
         begin
            addr_q_ff <= haddr_i;
            wr_pend_ff <= hwrite_i;
            rd_pend_ff <= ~hwrite_i;
            hreadyout_o <= hwrite_i;
         end
      end
   end

   always @*
   begin
      case (addr_q_ff)
         `SSAC_OFF_CTRL:
            nxt_rdata = ctrl_word(start_ff, cmd_ff, err_ff, al_succ_ff, al_stat_ff,
                                  al_dis_ff, rate_ff, addr_ff, data_ff);
         `SSAC_OFF_IRQ_STS:
            nxt_rdata = {{(32-`SSAC_IRQ_W){1'b0}}, irq_sts_ff};
         `SSAC_OFF_IRQ_MSK:
            nxt_rdata = {{(32-`SSAC_IRQ_W){1'b0}}, irq_msk_ff};
         default:
            nxt_rdata = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // eeprom clock divider
   // free running, so a new start may wait up to one quarter period
   // rate select
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         div_ff <= 6'h00;
         tick_ff <= 1'b0;
      end
      else if (rate_ff == `SSAC_RATE_TEST)
      begin
         // test mode: one quarter bit per system clock
         div_ff <= 6'h00;
         tick_ff <= 1'b1;
      end
      else if (div_ff == QTR_LAST)
      begin
         // reserved encodings run at the divided rate
         div_ff <= 6'h00;
         tick_ff <= 1'b1;
      end
      else
      begin
         div_ff <= div_ff + 6'h01;
         tick_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // control register
   assign al_good = autoload_done_i && autoload_ok_i && !al_dis_ff;

   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         start_ff <= 1'b0;
         cmd_ff <= 1'b0;
         err_ff <= 1'b0;
         al_succ_ff <= 1'b0;
         al_stat_ff <= 1'b0;
         al_dis_ff <= `SSAC_RST_AL_DIS;
         strap_taken_ff <= 1'b0;
         rate_ff <= `SSAC_RST_RATE;
         addr_ff <= `SSAC_RST_ADDR;
         data_ff <= `SSAC_RST_DATA;
         go_ff <= 1'b0;
         sda_o <= 1'b0;
      end
      else
      begin
         go_ff <= 1'b0;
         // strap caught once after reset release
         // strap is not read again; a new value needs another reset
         if (!strap_taken_ff)
         begin
            strap_taken_ff <= 1'b1;
            al_dis_ff <= ~autoload_en_i;
         end
         if (wr_ctrl)
         begin
            // direction held while a cycle runs; rate and address always take the write, data unless a read ends without nack in that cycle
            if (!start_ff)
               cmd_ff <= hwdata_i[`SSAC_B_CMD];
            rate_ff <= hwdata_i[`SSAC_F_RATE_HI:`SSAC_F_RATE_LO];
            addr_ff <= hwdata_i[`SSAC_F_ADDR_HI:`SSAC_F_ADDR_LO];
            data_ff <= hwdata_i[`SSAC_F_DATA_HI:`SSAC_F_DATA_LO];
         end
         if (wr_ctrl && hwdata_i[`SSAC_B_START] && !start_ff)
         begin
            start_ff <= 1'b1;
            go_ff <= 1'b1;
            err_ff <= 1'b0;
         end
         else if (eng_done)
         begin
            start_ff <= 1'b0;
            err_ff <= eng_nack;
            if (!cmd_ff && !eng_nack)
               data_ff <= eng_rdata;
         end
         // success shown, set wins over read clear
         if (al_good)
            al_succ_ff <= 1'b1;
         else if (rd_ctrl)
            al_succ_ff <= 1'b0;
         if (al_good)
            al_stat_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins
   assign irq_set = {al_good, eng_done & eng_nack, eng_done};
   assign irq_clr = (wr_pend_ff && addr_q_ff == `SSAC_OFF_IRQ_STS) ?
                    hwdata_i[`SSAC_IRQ_W-1:0] : {`SSAC_IRQ_W{1'b0}};
   assign nxt_irq_sts = irq_set | (irq_sts_ff & ~irq_clr);

   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         irq_sts_ff <= {`SSAC_IRQ_W{1'b0}};
         irq_msk_ff <= {`SSAC_IRQ_W{1'b0}};
         irq_o <= 1'b0;
      end
      else
      begin
         // irq follows next status so a clear drops it without a stale cycle
         irq_sts_ff <= nxt_irq_sts;
         if (wr_pend_ff && addr_q_ff == `SSAC_OFF_IRQ_MSK)
            irq_msk_ff <= hwdata_i[`SSAC_IRQ_W-1:0];
         irq_o <= |(nxt_irq_sts & irq_msk_ff);
      end
   end

   ////////////////////////////////////////////////////////////////
   // cycle engine
   // software polls start, not engine busy: start covers the go pulse cycle
   // engine latches cmd, address and data at go, so later writes are safe
   ssac_ee_engine #(
      .DEV_ADDR(DEV_ADDR)
   ) u_engine (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .tick_i(tick_ff),
      .go_i(go_ff),
      .wr_i(cmd_ff),
      .addr_i(addr_ff),
      .wdata_i(data_ff),
      .sda_i(sda_i),
      .busy_o(eng_busy),
      .done_o(eng_done),
      .nack_o(eng_nack),
      .rdata_o(eng_rdata),
      .scl_o(scl_o),
      .sda_oe_o(sda_oe_o)
   );

endmodule

/* design/ssac_eeprom_regs.vh */
// constants for the serial eeprom access control block
// assumes a 25 MHz system clock and a 125 MHz core link clock reference
`ifndef SSAC_EEPROM_REGS_VH
`define SSAC_EEPROM_REGS_VH

// register byte addresses
`define SSAC_OFF_CTRL 8'hbc
`define SSAC_OFF_IRQ_STS 8'hd0
`define SSAC_OFF_IRQ_MSK 8'hd4

// control register fields
`define SSAC_B_START 0
`define SSAC_B_CMD 1
`define SSAC_B_ERR 2
`define SSAC_B_AL_SUCC 3
`define SSAC_B_AL_STAT 4
`define SSAC_B_AL_DIS 5
`define SSAC_F_RATE_HI 7
`define SSAC_F_RATE_LO 6
`define SSAC_F_ADDR_HI 15
`define SSAC_F_ADDR_LO 9
`define SSAC_F_DATA_HI 31
`define SSAC_F_DATA_LO 16

// reset values
`define SSAC_RST_RATE 2'h1
`define SSAC_RST_AL_DIS 1'h1
`define SSAC_RST_ADDR 7'h00
`define SSAC_RST_DATA 16'h0000

// clock rate encodings
`define SSAC_RATE_DIV 2'h1
`define SSAC_RATE_TEST 2'h3

// interrupt status bits
`define SSAC_IRQ_W 3
`define SSAC_I_DONE 0
`define SSAC_I_ERR 1
`define SSAC_I_AL 2

// eeprom clock: core clock / 1024, one bit split in four quarter phases
`define SSAC_CORE_KHZ 125000
`define SSAC_SYS_KHZ 25000
`define SSAC_EE_DIV 1024
`define SSAC_QTR_CYC ((`SSAC_SYS_KHZ * `SSAC_EE_DIV + 4 * `SSAC_CORE_KHZ - 1) / (4 * `SSAC_CORE_KHZ))

// engine step kinds
`define SSAC_K_START 2'h0
`define SSAC_K_TX 2'h1
`define SSAC_K_RX 2'h2
`define SSAC_K_STOP 2'h3
`define SSAC_STEP_STOP_WR 3'h5
`define SSAC_STEP_STOP_RD 3'h7
`define SSAC_STEP_RD_HI 3'h5
`define SSAC_STEP_RD_LO 3'h6

`endif

/* design/ssac_ee_engine.v */
// two-wire eeprom cycle engine: one 16-bit word read or write per go pulse
// assumes tick_i is a one-cycle quarter-bit enable; sda is open drain
`include "ssac_eeprom_regs.vh"

module ssac_ee_engine #(
   parameter DEV_ADDR = 7'h50
)(
   input wire clk_sys_i,
   input wire nrst_i,
   input wire tick_i,
   input wire go_i,
   input wire wr_i,
   input wire [6:0] addr_i,
   input wire [15:0] wdata_i,
   input wire sda_i,
   output reg busy_o,
   output reg done_o,
   output reg nack_o,
   output reg [15:0] rdata_o,
   output reg scl_o,
   output reg sda_oe_o
);

   ////////////////////////////////////////////////////////////////
   reg wr_ff;
   reg [6:0] addr_ff;
   reg [15:0] wdata_ff;
   reg [2:0] step_ff;
   reg [1:0] q_ff;
   reg [3:0] bit_ff;
   reg [7:0] sh_ff;
   wire [1:0] kind;
   wire last_bit;

   // write: S dev addr hi lo P ; read: S dev addr Sr dev+r hi lo P
   function [1:0] step_kind;
      input wr;
      input [2:0] s;
      begin
         if (s == 3'h0 || (!wr && s == 3'h3))
            step_kind = `SSAC_K_START;
         else if ((wr && s == `SSAC_STEP_STOP_WR) || (!wr && s == `SSAC_STEP_STOP_RD))
            step_kind = `SSAC_K_STOP;
         else if (!wr && s >= `SSAC_STEP_RD_HI)
            step_kind = `SSAC_K_RX;
         else
            step_kind = `SSAC_K_TX;
      end
   endfunction

   function [7:0] tx_byte;
      input [2:0] s;
      input [6:0] a;
      input [15:0] d;
      begin
         case (s)
            3'h1: tx_byte = {DEV_ADDR[6:0], 1'b0};
            3'h2: tx_byte = {1'b0, a};
            3'h3: tx_byte = d[15:8];
            3'h4: tx_byte = (wr_ff) ? d[7:0] : {DEV_ADDR[6:0], 1'b1};
            default: tx_byte = 8'h00;
         endcase
      end
   endfunction

   assign kind = step_kind(wr_ff, step_ff);
   assign last_bit = (bit_ff == 4'h8);

   ////////////////////////////////////////////////////////////////
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_ff <= 1'b0;
         addr_ff <= 7'h00;
         wdata_ff <= 16'h0000;
         step_ff <= 3'h0;
         q_ff <= 2'h0;
         bit_ff <= 4'h0;
         sh_ff <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         nack_o <= 1'b0;
         rdata_o <= 16'h0000;
         scl_o <= 1'b1;
         sda_oe_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (!busy_o)
         begin
            if (go_i)
            begin
               wr_ff <= wr_i;
               addr_ff <= addr_i;
               wdata_ff <= wdata_i;
               step_ff <= 3'h0;
               q_ff <= 2'h0;
               bit_ff <= 4'h0;
               nack_o <= 1'b0;
               busy_o <= 1'b1;
            end
         end
         else if (tick_i)
         begin
            q_ff <= q_ff + 2'h1;
            case (kind)
               `SSAC_K_START:
               begin
                  // same shape serves first start and repeated start
                  case (q_ff)
                     2'h0: sda_oe_o <= 1'b0;
                     2'h1: scl_o <= 1'b1;
                     2'h2: sda_oe_o <= 1'b1;
                     default:
                     begin
                        scl_o <= 1'b0;
                        step_ff <= step_ff + 3'h1;
                        sh_ff <= tx_byte(step_ff + 3'h1, addr_ff, wdata_ff);
                     end
                  endcase
               end
               `SSAC_K_STOP:
               begin
                  case (q_ff)
                     2'h0:
                     begin
                        scl_o <= 1'b0;
                        sda_oe_o <= 1'b1;
                     end
                     2'h1: scl_o <= 1'b1;
                     2'h2: sda_oe_o <= 1'b0;
                     default:
                     begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                     end
                  endcase
               end
               default:
               begin
                  case (q_ff)
                     2'h0:
                     begin
                        // master acks the high read byte, nacks the last one
                        if (!last_bit)
                           sda_oe_o <= (kind == `SSAC_K_TX) ? ~sh_ff[7] : 1'b0;
                        else
                           sda_oe_o <= (kind == `SSAC_K_RX) && (step_ff == `SSAC_STEP_RD_HI);
                     end
                     2'h1: scl_o <= 1'b1;
                     2'h2:
                     begin
                        if (!last_bit)
                           sh_ff <= {sh_ff[6:0], (kind == `SSAC_K_RX) ? sda_i : 1'b0};
                        else if (kind == `SSAC_K_TX && sda_i)
                           nack_o <= 1'b1;
                     end
                     default:
                     begin
                        scl_o <= 1'b0;
                        if (!last_bit)
                           bit_ff <= bit_ff + 4'h1;
                        else
                        begin
                           bit_ff <= 4'h0;
                           if (step_ff == `SSAC_STEP_RD_HI && !wr_ff)
                              rdata_o[15:8] <= sh_ff;
                           if (step_ff == `SSAC_STEP_RD_LO && !wr_ff)
                              rdata_o[7:0] <= sh_ff;
                           // a refused byte ends the cycle with a stop
                           if (nack_o)
                              step_ff <= (wr_ff) ? `SSAC_STEP_STOP_WR : `SSAC_STEP_STOP_RD;
                           else
                           begin
                              step_ff <= step_ff + 3'h1;
                              sh_ff <= tx_byte(step_ff + 3'h1, addr_ff, wdata_ff);
                           end
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end

endmodule

/* sim/ssac_eeprom_monitor.sv */
// port checker for the eeprom access control block
// assumes one clock domain and the active-low asynchronous reset
module ssac_eeprom_monitor (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire hsel_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire [31:0] hrdata_o,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire scl_o,
   input wire sda_oe_o,
   input wire sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   ////////////////////
   sequence s_rd_taken;
      hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   endsequence
   sequence s_wr_taken;
      hsel_i && hready_i && htrans_i[1] && hwrite_i;
   endsequence
   sequence s_one_wait;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   // quarter phase is at most 52 cycles
   sequence s_scl_fall;
      ##[1:60] !scl_o;
   endsequence
   ////////////////////
   property p_rd_wait;
      s_rd_taken |=> s_one_wait;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_nowait;
      s_wr_taken |=> hreadyout_o;
   endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   property p_okay;
      hresp_o == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rdata_hold;
      !$stable(hrdata_o) |-> $past(hreadyout_o) == 1'b0;
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_open_drain;
      sda_o == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda value not low");
   property p_scl_hi_min;
      $rose(scl_o) |=> scl_o;
   endproperty
   a_scl_hi_min: assert property (p_scl_hi_min) else $error("scl high too short");
   property p_scl_lo_min;
      $fell(scl_o) |=> !scl_o;
   endproperty
   a_scl_lo_min: assert property (p_scl_lo_min) else $error("scl low too short");
   property p_stop_idle;
      $fell(sda_oe_o) && scl_o |=> scl_o [*2];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
   property p_start_hold;
      $rose(sda_oe_o) && scl_o |-> sda_oe_o throughout s_scl_fall;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start not held");
endmodule

/* sim/ssac_ee_partner.sv */
// behavioural two-wire eeprom: 128 words, high byte first
// assumes a pull-up on sda; changes its sda pull only when scl falls
module ssac_ee_partner #(
   parameter logic [6:0] DEV = 7'h50
)(
   input wire scl_i,
   input wire sda_i,
   input wire nack_i,
   output logic sda_pull_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:127];
   logic [15:0] tx = 16'h0;
   logic [7:0] sh = 8'h00;
   logic [7:0] hi = 8'h00;
   logic [6:0] wa = 7'h00;
   logic ack = 1'b0;
   logic snd = 1'b0;
   int nbit = 0;
   int nbyte = 0;
   ////////////////////
   always @(negedge sda_i)
      if (scl_i)
      begin
         nbit = 0;
         nbyte = 0;
         ack = 1'b0;
         snd = 1'b0;
      end
   always @(posedge sda_i)
      if (scl_i)
         snd = 1'b0;
   always @(posedge scl_i)
      if (!ack && nbit < 8)
      begin
         sh = {sh[6:0], sda_i};
         tx = tx << 1;
         nbit = nbit + 1;
      end
   always @(negedge scl_i)
      if (ack)
      begin
         ack = 1'b0;
         nbit = 0;
         if (nbyte == 1)
            tx = mem[wa];
         if (nbyte == 3)
            snd = 1'b0;
         sda_pull_o = snd && !tx[15];
      end
      else if (nbit == 8)
      begin
         ack = 1'b1;
         // ack only when told and addressed
         sda_pull_o = !snd && !nack_i && (nbyte != 0 || sh[7:1] == DEV);
         if (sda_pull_o)
            case (nbyte)
               0: snd = sh[0];
               1: wa = sh[6:0];
               2: hi = sh;
               3: mem[wa] = {hi, sh};
            endcase
         nbyte = nbyte + 1;
      end
      else
         sda_pull_o = snd && !tx[15];
endmodule

/* sim/ssac_eeprom_ctrl_tb.sv */
// bench for the eeprom access control block: ahb tasks, eeprom model, checks
// assumes the checker is bound to the design and the model answers device 50
`include "ssac_eeprom_regs.vh"

module ssac_eeprom_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CTRL = `SSAC_OFF_CTRL;
   localparam logic [7:0] STS = `SSAC_OFF_IRQ_STS;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic al_en = 1'b1;
   logic al_done = 1'b0;
   logic al_ok = 1'b0;
   logic scl;
   logic sda_oe;
   logic pull;
   logic irq;
   logic nack = 1'b0;
   wire sda_w = ~(sda_oe | pull);
   logic [31:0] vlast;
   logic [1:0] rates [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
   int n_errors = 0;
   int num_checks = 0;
   int hi_cnt = 0;
   int hi_len = 0;
   always #20 clk_sys = ~clk_sys;
   ////////////////////
   ssac_eeprom_ctrl #(.DEV_ADDR(7'h50)) u_ssac_eeprom_ctrl (
      .clk_sys_i(clk_sys), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hready_i(hready), .hwdata_i(hwdata),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .autoload_en_i(al_en),
      .autoload_done_i(al_done), .autoload_ok_i(al_ok), .sda_i(sda_w), .scl_o(scl),
      .sda_oe_o(sda_oe), .sda_o(), .irq_o(irq));
   ssac_ee_partner #(.DEV(7'h50)) u_ssac_ee_partner (
      .scl_i(scl), .sda_i(sda_w), .nack_i(nack), .sda_pull_o(pull));
   // length of the last scl high phase
   always @(posedge clk_sys)
      if (scl === 1'b1)
         hi_cnt <= hi_cnt + 1;
      else
      begin
         if (hi_cnt != 0)
            hi_len <= hi_cnt;
         hi_cnt <= 0;
      end
   ////////////////////
   task automatic report_and_stop;
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic edge_rdy;
      @(posedge clk_sys);
      while (hready !== 1'b1)
         @(posedge clk_sys);
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      edge_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      edge_rdy();
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      xfer(1'b0, a, 32'h0, v);
      check(v, exp);
   endtask
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk_sys);
      check({31'h0, irq}, {31'h0, e});
   endtask
   function automatic logic [31:0] cv(input logic [15:0] d, input logic [6:0] a,
      input logic [1:0] r, input logic [5:0] lo);
      return {d, a, 1'b0, r, lo};
   endfunction
   // start one cycle, then poll until start clears
   task automatic run(input logic [15:0] d, input logic [6:0] a, input logic [1:0] r,
      input logic c);
      xfer(1'b1, CTRL, cv(d, a, r, {4'h0, c, 1'b1}), vlast);
      xfer(1'b0, CTRL, 32'h0, vlast);
      check({31'h0, vlast[0]}, 32'h1);
      while (vlast[0] !== 1'b0)
         xfer(1'b0, CTRL, 32'h0, vlast);
   endtask
   task automatic autoload(input logic ok);
      al_done <= 1'b1;
      al_ok <= ok;
      @(posedge clk_sys);
      al_done <= 1'b0;
      @(posedge clk_sys);
   endtask
   ////////////////////
   initial
   begin
      u_ssac_ee_partner.mem[7'h05] = 16'h0f0f;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd_chk(CTRL, 32'h40);
      rd_chk(8'h00, 32'h0);
      xfer(1'b1, 8'h10, 32'hffff_ffff, vlast);
      rd_chk(8'h10, 32'h0);
      xfer(1'b1, CTRL, 32'hffff_fffe, vlast);
      rd_chk(CTRL, cv(16'hffff, 7'h7f, 2'h3, 6'h02));
      foreach (rates[i])
      begin
         run(16'ha5c3 + 16'(i), 7'h2a, rates[i], 1'b1);
         check(vlast, cv(16'ha5c3 + 16'(i), 7'h2a, rates[i], 6'h02));
         check({16'h0, u_ssac_ee_partner.mem[7'h2a]}, {16'h0, 16'ha5c3 + 16'(i)});
         check(32'(hi_len), (rates[i] == 2'h3) ? 32'h2 : 32'(2 * `SSAC_QTR_CYC));
      end
      run(16'h0000, 7'h2a, 2'h3, 1'b0);
      check(vlast, cv(16'ha5c6, 7'h2a, 2'h3, 6'h00));
      rd_chk(STS, 32'h1);
      irq_chk(1'b0);
      xfer(1'b1, `SSAC_OFF_IRQ_MSK, 32'h7, vlast);
      irq_chk(1'b1);
      xfer(1'b1, STS, 32'h1, vlast);
      irq_chk(1'b0);
      nack <= 1'b1;
      run(16'h1234, 7'h05, 2'h3, 1'b1);
      check(vlast, cv(16'h1234, 7'h05, 2'h3, 6'h06));
      check({16'h0, u_ssac_ee_partner.mem[7'h05]}, 32'h0f0f);
      run(16'h1234, 7'h2a, 2'h3, 1'b0);
      check(vlast, cv(16'h1234, 7'h2a, 2'h3, 6'h04));
      rd_chk(STS, 32'h3);
      irq_chk(1'b1);
      nack <= 1'b0;
      xfer(1'b1, STS, 32'h7, vlast);
      autoload(1'b1);
      rd_chk(CTRL, cv(16'h1234, 7'h2a, 2'h3, 6'h1c));
      rd_chk(CTRL, cv(16'h1234, 7'h2a, 2'h3, 6'h14));
      rd_chk(STS, 32'h4);
      // second reset with autoload disabled
      nrst <= 1'b0;
      al_en <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd_chk(CTRL, 32'h60);
      autoload(1'b1);
      rd_chk(CTRL, 32'h60);
      rd_chk(STS, 32'h0);
      report_and_stop();
   end
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      report_and_stop();
   end
endmodule

bind ssac_eeprom_ctrl ssac_eeprom_monitor u_ssac_eeprom_monitor (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_o(scl_o),
   .sda_oe_o(sda_oe_o), .sda_o(sda_o));
